// [src/cpu_load_or_multiply_decode.v]
// decode and execution sequencer for the load, multiply and or subset
// Overview of operation
// - xC loads immediate byte into working register; 2 bytes, 2 cycles.
// - C2 loads working register from program memory at pair; 5 cycles.
// - C3 copies program byte to register at pointer; 9 cycles.
// - D3 stores to program memory, then bumps pointer and pair; 9 cycles.
// - 82 loads working register from external data at pair; 5 cycles.
// - 83 copies external data byte to register at pointer; 9 cycles.
// - 93 stores to external data, then bumps pointer and pair.
// - 84 loads working register from a 12-bit register address; 2 cycles.
// - 98 writes register plus signed index, no memory access; 3 cycles.
// - F4 multiplies pair high by low, 16-bit result to pair; 8 cycles.
// - 0F does nothing for 2 cycles, one byte.
// - 42 ors two working registers; sets Z,S, clears V; 3 cycles.
// - 48 ors two 12-bit addressed registers, same flags; 3 cycles.
// - bit operand is a 3-bit field selecting bits 0 to 7.
// - relative operand is signed byte added to next instruction address.
// - extended register operand is a 12-bit address 000 to FFF.
// - direct address operand is 16 bits, 0000 to FFFF.
// - indirect register pair operand is a 4-bit working register field, low bit ignored.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_load_defines.vh"
module cpu_load_or_multiply_decode (
  input wire sys_clk,
  input wire resetn,
  input wire instr_valid,
  input wire [7:0] instr_op,
  input wire [7:0] instr_b1,
  input wire [7:0] instr_b2,
  input wire [7:0] instr_b3,
  input wire [15:0] next_pc,
  input wire [7:0] reg_ptr,
  input wire [5:0] flags_in,
  input wire [7:0] rf_rdata,
  input wire [7:0] mem_rdata,
  output wire instr_ready,
  output wire done,
  output wire foreign,
  output wire [2:0] fetch_len,
  output wire [11:0] rf_addr,
  output wire rf_rd,
  output wire rf_we,
  output wire [7:0] rf_wdata,
  output wire [15:0] mem_addr,
  output wire mem_space,
  output wire mem_rd,
  output wire mem_we,
  output wire [7:0] mem_wdata,
  output wire [5:0] flags_out,
  output wire flags_we,
  output wire [7:0] bit_mask,
  output wire [15:0] rel_target,
  output wire [15:0] direct_addr
);

  localparam [11:0] S_IDLE = 12'h001;
  localparam [11:0] S_RD1 = 12'h002;
  localparam [11:0] S_RD2 = 12'h004;
  localparam [11:0] S_RD3 = 12'h008;
  localparam [11:0] S_RD4 = 12'h010;
  localparam [11:0] S_MEM = 12'h020;
  localparam [11:0] S_MUL = 12'h040;
  localparam [11:0] S_WR1 = 12'h080;
  localparam [11:0] S_WR2 = 12'h100;
  localparam [11:0] S_WR3 = 12'h200;
  localparam [11:0] S_WR4 = 12'h400;
  localparam [11:0] S_HOLD = 12'h800;

  reg [11:0] state_r, state_nxt;
  reg [3:0] cnt_r, cnt_nxt;
  reg [3:0] ncyc_r;
  reg [3:0] cls_r;
  reg [7:0] b1_r, b2_r, b3_r;
  reg [7:0] a_r, a_nxt;
  reg [7:0] b_r, b_nxt;
  reg [7:0] c_r, c_nxt;
  reg done_r, done_nxt;
  reg foreign_r, foreign_nxt;
  reg [2:0] fetch_len_r;
  reg [11:0] rf_addr_r, rf_addr_nxt;
  reg rf_rd_r, rf_rd_nxt;
  reg rf_we_r, rf_we_nxt;
  reg [7:0] rf_wdata_r, rf_wdata_nxt;
  reg [15:0] mem_addr_r, mem_addr_nxt;
  reg mem_space_r;
  reg mem_rd_r, mem_rd_nxt;
  reg mem_we_r, mem_we_nxt;
  reg [7:0] mem_wdata_r, mem_wdata_nxt;
  reg [5:0] flags_r, flags_nxt;
  reg flags_we_r, flags_we_nxt;
  reg [7:0] bit_mask_r;
  reg [15:0] rel_target_r;
  reg [15:0] direct_addr_r;
  reg [7:0] res;
  reg [3:0] ptr_fld;
  reg [3:0] pair_fld;

  wire [3:0] tbl_cls;
  wire [3:0] tbl_ncyc;
  wire [2:0] tbl_len;
  wire tbl_space;
  wire [15:0] prod;
  wire [15:0] pair_inc;
  wire idle;
  wire accept;

  // working register n lives in the page named by the pointer
  function [11:0] wreg;
    input [3:0] n;
    begin
      wreg = {reg_ptr, n};
    end
  endfunction

  // pair halves: even register holds the high byte
  function [11:0] pair_reg;
    input [3:0] p;
    input lo;
    begin
      pair_reg = {reg_ptr, p[3:1], lo};
    end
  endfunction

  // 8-bit register number placed in the fixed page
  function [11:0] short_reg;
    input [7:0] r;
    begin
      short_reg = {`SHORT_PAGE, r};
    end
  endfunction

  opcode_table u_table (
    .opcode(instr_op),
    .op_class(tbl_cls),
    .ncyc(tbl_ncyc),
    .nbytes(tbl_len),
    .space(tbl_space)
  );

  byte_product #(
    .W(8)
  ) u_mul (
    .mul_a(a_r),
    .mul_b(b_r),
    .product(prod)
  );

  assign idle = state_r[0];
  assign accept = idle & instr_valid & (tbl_cls != `CLS_NONE);
  assign pair_inc = {a_r, b_r} + 16'h0001;

  // step logic: each transition sets the outputs of the next step
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    a_nxt = a_r;
    b_nxt = b_r;
    c_nxt = c_r;
    rf_addr_nxt = rf_addr_r;
    rf_wdata_nxt = rf_wdata_r;
    rf_rd_nxt = 1'b0;
    rf_we_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    mem_rd_nxt = 1'b0;
    mem_we_nxt = 1'b0;
    flags_nxt = flags_r;
    flags_we_nxt = 1'b0;
    foreign_nxt = 1'b0;
    res = a_r | rf_rdata;
    ptr_fld = (cls_r == `CLS_MLOAD_AI) ? b1_r[7:4] : b1_r[3:0];
    pair_fld = (cls_r == `CLS_MLOAD_AI) ? b1_r[3:0] : b1_r[7:4];
    case (state_r)
      S_IDLE: begin
        if (instr_valid) begin
          cnt_nxt = 4'h1;
          state_nxt = S_RD1;
          rf_rd_nxt = 1'b1;
          case (tbl_cls)
            `CLS_IMM: begin
              state_nxt = S_WR1;
              rf_rd_nxt = 1'b0;
              rf_we_nxt = 1'b1;
              rf_addr_nxt = wreg(instr_op[7:4]);
              rf_wdata_nxt = instr_b1;
            end
            `CLS_MLOAD: rf_addr_nxt = pair_reg(instr_b1[3:0], 1'b0);
            `CLS_MLOAD_AI: rf_addr_nxt = wreg(instr_b1[7:4]);
            `CLS_MSTORE_AI: rf_addr_nxt = wreg(instr_b1[3:0]);
            `CLS_XLD: rf_addr_nxt = {instr_b1[3:0], instr_b2};
            `CLS_EAC: rf_addr_nxt = wreg(instr_b1[3:0]);
            `CLS_MUL:
              rf_addr_nxt = short_reg({instr_b1[7:1], 1'b0});
            `CLS_OR: rf_addr_nxt = wreg(instr_b1[7:4]);
            `CLS_ORX: rf_addr_nxt = {instr_b1, instr_b2[7:4]};
            `CLS_IDLE: begin
              state_nxt = S_HOLD;
              rf_rd_nxt = 1'b0;
            end
            default: begin
              state_nxt = S_IDLE;
              rf_rd_nxt = 1'b0;
              foreign_nxt = 1'b1;
            end
          endcase
        end
      end
      S_RD1: begin
        a_nxt = rf_rdata;
        c_nxt = rf_rdata;
        state_nxt = S_RD2;
        rf_rd_nxt = 1'b1;
        case (cls_r)
          `CLS_MLOAD: rf_addr_nxt = pair_reg(b1_r[3:0], 1'b1);
          `CLS_MLOAD_AI: rf_addr_nxt = pair_reg(b1_r[3:0], 1'b0);
          `CLS_MSTORE_AI: rf_addr_nxt = pair_reg(b1_r[7:4], 1'b0);
          `CLS_MUL: rf_addr_nxt = short_reg({b1_r[7:1], 1'b1});
          `CLS_OR: rf_addr_nxt = wreg(b1_r[3:0]);
          `CLS_ORX: rf_addr_nxt = {b2_r[3:0], b3_r};
          `CLS_XLD, `CLS_EAC: begin
            state_nxt = S_WR1;
            rf_rd_nxt = 1'b0;
            rf_we_nxt = 1'b1;
            rf_addr_nxt = wreg(b1_r[7:4]);
            rf_wdata_nxt = rf_rdata;
            if (cls_r == `CLS_EAC) begin
              rf_wdata_nxt = rf_rdata + b2_r;
            end
          end
          default: state_nxt = S_HOLD;
        endcase
      end
      S_RD2: begin
        state_nxt = S_HOLD;
        case (cls_r)
          `CLS_MLOAD: begin
            state_nxt = S_MEM;
            mem_rd_nxt = 1'b1;
            mem_addr_nxt = {a_r, rf_rdata};
          end
          `CLS_MLOAD_AI, `CLS_MSTORE_AI: begin
            a_nxt = rf_rdata;
            state_nxt = S_RD3;
            rf_rd_nxt = 1'b1;
            rf_addr_nxt = pair_reg(pair_fld, 1'b1);
          end
          `CLS_MUL: begin
            b_nxt = rf_rdata;
            state_nxt = S_MUL;
          end
          `CLS_OR, `CLS_ORX: begin
            state_nxt = S_WR1;
            rf_we_nxt = 1'b1;
            rf_wdata_nxt = res;
            rf_addr_nxt = (cls_r == `CLS_OR) ? wreg(b1_r[7:4]) :
              {b2_r[3:0], b3_r};
            flags_we_nxt = 1'b1;
            flags_nxt = flags_in;
            flags_nxt[`FLG_Z] = (res == 8'h00);
            flags_nxt[`FLG_S] = res[7];
            flags_nxt[`FLG_V] = 1'b0;
          end
          default: state_nxt = S_HOLD;
        endcase
      end
      S_RD3: begin
        b_nxt = rf_rdata;
        if (cls_r == `CLS_MSTORE_AI) begin
          state_nxt = S_RD4;
          rf_rd_nxt = 1'b1;
          rf_addr_nxt = short_reg(c_r);
        end else begin
          state_nxt = S_MEM;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = {a_r, rf_rdata};
        end
      end
      S_RD4: begin
        state_nxt = S_MEM;
        mem_we_nxt = 1'b1;
        mem_addr_nxt = {a_r, b_r};
        mem_wdata_nxt = rf_rdata;
      end
      S_MEM: begin
        rf_we_nxt = 1'b1;
        if (cls_r == `CLS_MSTORE_AI) begin
          state_nxt = S_WR2;
          rf_addr_nxt = wreg(ptr_fld);
          rf_wdata_nxt = c_r + 8'h01;
        end else begin
          state_nxt = S_WR1;
          rf_wdata_nxt = mem_rdata;
          rf_addr_nxt = (cls_r == `CLS_MLOAD) ? wreg(b1_r[7:4]) :
            short_reg(c_r);
        end
      end
      S_MUL: begin
        state_nxt = S_WR1;
        rf_we_nxt = 1'b1;
        rf_addr_nxt = short_reg({b1_r[7:1], 1'b0});
        rf_wdata_nxt = prod[15:8];
      end
      S_WR1: begin
        state_nxt = S_HOLD;
        if (cls_r == `CLS_MUL) begin
          state_nxt = S_WR2;
          rf_we_nxt = 1'b1;
          rf_addr_nxt = short_reg({b1_r[7:1], 1'b1});
          rf_wdata_nxt = prod[7:0];
        end else if (cls_r == `CLS_MLOAD_AI) begin
          state_nxt = S_WR2;
          rf_we_nxt = 1'b1;
          rf_addr_nxt = wreg(ptr_fld);
          rf_wdata_nxt = c_r + 8'h01;
        end
      end
      S_WR2: begin
        state_nxt = S_HOLD;
        if (cls_r != `CLS_MUL) begin
          state_nxt = S_WR3;
          rf_we_nxt = 1'b1;
          rf_addr_nxt = pair_reg(pair_fld, 1'b1);
          rf_wdata_nxt = pair_inc[7:0];
        end
      end
      S_WR3: begin
        state_nxt = S_WR4;
        rf_we_nxt = 1'b1;
        rf_addr_nxt = pair_reg(pair_fld, 1'b0);
        rf_wdata_nxt = pair_inc[15:8];
      end
      S_WR4: state_nxt = S_HOLD;
      S_HOLD: state_nxt = S_HOLD;
      default: state_nxt = S_IDLE;
    endcase
    // pad every instruction out to its documented cycle count
    if (!idle) begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == ncyc_r) begin
        state_nxt = S_IDLE;
        rf_rd_nxt = 1'b0;
        rf_we_nxt = 1'b0;
        mem_rd_nxt = 1'b0;
        mem_we_nxt = 1'b0;
        flags_we_nxt = 1'b0;
      end
    end
    done_nxt = (state_nxt != S_IDLE) &&
      (cnt_nxt == (idle ? tbl_ncyc : ncyc_r));
  end

  // state, operands and output registers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      ncyc_r <= 4'h0;
      cls_r <= `CLS_NONE;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      a_r <= 8'h00;
      b_r <= 8'h00;
      c_r <= 8'h00;
      done_r <= 1'b0;
      foreign_r <= 1'b0;
      fetch_len_r <= 3'h0;
      rf_addr_r <= 12'h000;
      rf_rd_r <= 1'b0;
      rf_we_r <= 1'b0;
      rf_wdata_r <= 8'h00;
      mem_addr_r <= 16'h0000;
      mem_space_r <= `SPACE_PROG;
      mem_rd_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_wdata_r <= 8'h00;
      flags_r <= 6'h00;
      flags_we_r <= 1'b0;
      bit_mask_r <= 8'h00;
      rel_target_r <= 16'h0000;
      direct_addr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      a_r <= a_nxt;
      b_r <= b_nxt;
      c_r <= c_nxt;
      done_r <= done_nxt;
      foreign_r <= foreign_nxt;
      rf_addr_r <= rf_addr_nxt;
      rf_rd_r <= rf_rd_nxt;
      rf_we_r <= rf_we_nxt;
      rf_wdata_r <= rf_wdata_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_we_r <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      flags_r <= flags_nxt;
      flags_we_r <= flags_we_nxt;
      if (accept) begin
        ncyc_r <= tbl_ncyc;
        cls_r <= tbl_cls;
        b1_r <= instr_b1;
        b2_r <= instr_b2;
        b3_r <= instr_b3;
        fetch_len_r <= tbl_len;
        mem_space_r <= tbl_space;
        bit_mask_r <= 8'h01 << instr_b1[2:0];
        rel_target_r <= next_pc + {{8{instr_b1[7]}}, instr_b1};
        direct_addr_r <= {instr_b1, instr_b2};
      end
    end
  end

  assign instr_ready = state_r[0];
  assign done = done_r;
  assign foreign = foreign_r;
  assign fetch_len = fetch_len_r;
  assign rf_addr = rf_addr_r;
  assign rf_rd = rf_rd_r;
  assign rf_we = rf_we_r;
  assign rf_wdata = rf_wdata_r;
  assign mem_addr = mem_addr_r;
  assign mem_space = mem_space_r;
  assign mem_rd = mem_rd_r;
  assign mem_we = mem_we_r;
  assign mem_wdata = mem_wdata_r;
  assign flags_out = flags_r;
  assign flags_we = flags_we_r;
  assign bit_mask = bit_mask_r;
  assign rel_target = rel_target_r;
  assign direct_addr = direct_addr_r;

endmodule // cpu_load_or_multiply_decode
`default_nettype wire

// [pkg/cpu_load_defines.vh]
// opcodes, cycle counts, byte counts, classes and flag positions
`ifndef CPU_LOAD_DEFINES_VH
`define CPU_LOAD_DEFINES_VH

// opcodes of the decoded subset
`define OPC_IMM_LO 4'hC
`define OPC_PCL 8'hC2
`define OPC_PCL_AI 8'hC3
`define OPC_PCS_AI 8'hD3
`define OPC_EDL 8'h82
`define OPC_EDL_AI 8'h83
`define OPC_EDS_AI 8'h93
`define OPC_XLD 8'h84
`define OPC_EAC 8'h98
`define OPC_MUL 8'hF4
`define OPC_IDLE 8'h0F
`define OPC_OR 8'h42
`define OPC_ORX 8'h48

// execution cycle counts
`define CYC_IMM 4'h2
`define CYC_MLOAD 4'h5
`define CYC_AI 4'h9
`define CYC_XLD 4'h2
`define CYC_EAC 4'h3
`define CYC_MUL 4'h8
`define CYC_IDLE 4'h2
`define CYC_OR 4'h3
`define CYC_ORX 4'h3

// fetched byte counts
`define LEN_1 3'h1
`define LEN_2 3'h2
`define LEN_3 3'h3
`define LEN_4 3'h4

// instruction classes
`define CLS_NONE 4'h0
`define CLS_IMM 4'h1
`define CLS_MLOAD 4'h2
`define CLS_MLOAD_AI 4'h3
`define CLS_MSTORE_AI 4'h4
`define CLS_XLD 4'h5
`define CLS_EAC 4'h6
`define CLS_MUL 4'h7
`define CLS_IDLE 4'h8
`define CLS_OR 4'h9
`define CLS_ORX 4'hA

// memory spaces
`define SPACE_PROG 1'b0
`define SPACE_EXT 1'b1

// page used for 8-bit register addresses
`define SHORT_PAGE 4'h0

// flag bit positions in the flag byte
`define FLG_C 5
`define FLG_Z 4
`define FLG_S 3
`define FLG_V 2
`define FLG_D 1
`define FLG_H 0

`endif

// [src/opcode_table.v]
// opcode lookup: class, cycle count, byte count and memory space
`timescale 1ns/1ps
`default_nettype none
`include "cpu_load_defines.vh"
module opcode_table (
  input wire [7:0] opcode,
  output reg [3:0] op_class,
  output reg [3:0] ncyc,
  output reg [2:0] nbytes,
  output reg space
);

  // table of the decoded subset, anything else is foreign
  always @* begin
    op_class = `CLS_NONE;
    ncyc = 4'h0;
    nbytes = `LEN_2;
    space = `SPACE_PROG;
    if (opcode[3:0] == `OPC_IMM_LO) begin
      op_class = `CLS_IMM;
      ncyc = `CYC_IMM;
    end else begin
      case (opcode)
        `OPC_PCL: begin
          op_class = `CLS_MLOAD;
          ncyc = `CYC_MLOAD;
        end
        `OPC_PCL_AI: begin
          op_class = `CLS_MLOAD_AI;
          ncyc = `CYC_AI;
        end
        `OPC_PCS_AI: begin
          op_class = `CLS_MSTORE_AI;
          ncyc = `CYC_AI;
        end
        `OPC_EDL: begin
          op_class = `CLS_MLOAD;
          ncyc = `CYC_MLOAD;
          space = `SPACE_EXT;
        end
        `OPC_EDL_AI: begin
          op_class = `CLS_MLOAD_AI;
          ncyc = `CYC_AI;
          space = `SPACE_EXT;
        end
        `OPC_EDS_AI: begin
          op_class = `CLS_MSTORE_AI;
          ncyc = `CYC_AI;
          space = `SPACE_EXT;
        end
        `OPC_XLD: begin
          op_class = `CLS_XLD;
          ncyc = `CYC_XLD;
          nbytes = `LEN_3;
        end
        `OPC_EAC: begin
          op_class = `CLS_EAC;
          ncyc = `CYC_EAC;
          nbytes = `LEN_3;
        end
        `OPC_MUL: begin
          op_class = `CLS_MUL;
          ncyc = `CYC_MUL;
        end
        `OPC_IDLE: begin
          op_class = `CLS_IDLE;
          ncyc = `CYC_IDLE;
          nbytes = `LEN_1;
        end
        `OPC_OR: begin
          op_class = `CLS_OR;
          ncyc = `CYC_OR;
        end
        `OPC_ORX: begin
          op_class = `CLS_ORX;
          ncyc = `CYC_ORX;
          nbytes = `LEN_4;
        end
        default: op_class = `CLS_NONE;
      endcase
    end
  end

endmodule // opcode_table
`default_nettype wire

// [src/byte_product.v]
// unsigned 8x8 multiplier built from shifted partial products
`timescale 1ns/1ps
`default_nettype none
module byte_product #(
  parameter W = 8
) (
  input wire [W-1:0] mul_a,
  input wire [W-1:0] mul_b,
  output wire [2*W-1:0] product
);

  wire [2*W-1:0] acc [0:W];

  assign acc[0] = {(2*W){1'b0}};

  // one partial product per multiplier bit
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pp
      assign acc[i+1] = acc[i] +
        ({(2*W){mul_b[i]}} & ({{W{1'b0}}, mul_a} << i));
    end
  endgenerate

  assign product = acc[W];

endmodule // byte_product
`default_nettype wire

// [testbench/cpu_load_or_multiply_decode_props.sv]
// port-level checks for the load, multiply and or decoder
`timescale 1ns/1ps
`default_nettype none
module decode_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  input wire logic [15:0] next_pc,
  input wire logic [7:0] reg_ptr,
  input wire logic [5:0] flags_in,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic foreign,
  input wire logic [11:0] rf_addr,
  input wire logic rf_rd,
  input wire logic rf_we,
  input wire logic [7:0] rf_wdata,
  input wire logic mem_space,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [5:0] flags_out,
  input wire logic flags_we,
  input wire logic [7:0] bit_mask,
  input wire logic [15:0] rel_target,
  input wire logic [15:0] direct_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // an instruction is taken on this edge
  wire logic acc = instr_ready && instr_valid;
  // opcodes of the handled subset
  function automatic logic known(input logic [7:0] o);
    known = o[3:0] == 4'hC || o inside {8'hC2, 8'hC3, 8'hD3, 8'h82,
      8'h83, 8'h93, 8'h84, 8'h98, 8'hF4, 8'h0F, 8'h42, 8'h48};
  endfunction
  property p_imm;
    acc && instr_op[3:0] == 4'hC |=> rf_we && rf_wdata == $past(instr_b1)
      && rf_addr == {$past(reg_ptr), $past(instr_op[7:4])} ##1 done;
  endproperty
  a_imm: assert property (p_imm) else $error("imm load wrong");
  property p_mload;
    acc && (instr_op == 8'hC2 || instr_op == 8'h82) |-> ##3 mem_rd
      && mem_space == !$past(instr_op[6], 3) ##2 done;
  endproperty
  a_mload: assert property (p_mload)
    else $error("memory load wrong");
  property p_ai;
    acc && instr_op inside {8'hC3, 8'hD3, 8'h83, 8'h93}
      |-> ##1 (!done)[*8] ##1 done;
  endproperty
  a_ai: assert property (p_ai)
    else $error("auto-inc length");
  property p_store;
    acc && (instr_op == 8'hD3 || instr_op == 8'h93) |-> ##5 mem_we
      && mem_space == !$past(instr_op[6], 5);
  endproperty
  a_store: assert property (p_store)
    else $error("store wrong");
  property p_xld;
    acc && instr_op == 8'h84 |=> rf_rd
      && rf_addr == {$past(instr_b1[3:0]), $past(instr_b2)} ##1 rf_we && done;
  endproperty
  a_xld: assert property (p_xld)
    else $error("extended load wrong");
  property p_eac;
    acc && instr_op == 8'h98 |-> ##2 rf_we
      && rf_addr == {$past(reg_ptr, 2), $past(instr_b1[7:4], 2)} ##1 done;
  endproperty
  a_eac: assert property (p_eac) else $error("address sum wrong");
  property p_mul;
    acc && instr_op == 8'hF4 |-> ##1 (!done)[*7] ##1 done;
  endproperty
  a_mul: assert property (p_mul) else $error("product length");
  property p_idle;
    acc && instr_op == 8'h0F |=> (!rf_we && !mem_we && !flags_we)[*2] ##0 done;
  endproperty
  a_idle: assert property (p_idle) else $error("idle op wrong");
  property p_or;
    acc && (instr_op == 8'h42 || instr_op == 8'h48) |-> ##3 flags_we && done
      && flags_out == {flags_in[5], rf_wdata == 8'h00, rf_wdata[7], 1'b0,
      flags_in[1:0]};
  endproperty
  a_or: assert property (p_or) else $error("or flags");
  property p_foreign;
    acc && !known(instr_op) |=> foreign && instr_ready && !rf_we && !mem_we
      && !flags_we;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign op acted");
  property p_busy;
    acc && known(instr_op) |=> !instr_ready && !foreign;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  property p_opnd;
    acc && known(instr_op) |=> bit_mask == 8'h01 << $past(instr_b1[2:0])
      && direct_addr == {$past(instr_b1), $past(instr_b2)};
  endproperty
  a_opnd: assert property (p_opnd)
    else $error("operand fields wrong");
  property p_rel;
    acc && known(instr_op) |=> rel_target == $past(next_pc) +
      {{8{$past(instr_b1[7])}}, $past(instr_b1)};
  endproperty
  a_rel: assert property (p_rel) else $error("rel target wrong");
endmodule // decode_props
`default_nettype wire

// [testbench/mem_model.sv]
// register file, program and external memory beside the decoder
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic sys_clk,
  input wire logic [11:0] rf_addr,
  input wire logic rf_rd,
  input wire logic rf_we,
  input wire logic [7:0] rf_wdata,
  input wire logic [15:0] mem_addr,
  input wire logic mem_space,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] rf_rdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] rf [0:4095];
  logic [7:0] pm [0:65535];
  logic [7:0] xm [0:65535];
  logic [7:0] junk = 8'h5A;
  // data only while strobed, changing noise otherwise
  always_comb rf_rdata = rf_rd ? rf[rf_addr] : junk;
  always_comb mem_rdata = !mem_rd ? ~junk : mem_space ? xm[mem_addr]
    : pm[mem_addr];
  // writes land on the rising edge
  always @(posedge sys_clk) begin
    junk <= junk + 8'h3B;
    if (rf_we)
      rf[rf_addr] <= rf_wdata;
    if (mem_we && mem_space)
      xm[mem_addr] <= mem_wdata;
    if (mem_we && !mem_space)
      pm[mem_addr] <= mem_wdata;
  end
endmodule // mem_model
`default_nettype wire

// [testbench/cpu_load_or_multiply_decode_tb.sv]
// self-checking bench for the load, multiply and or decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(g, e)
module cpu_load_or_multiply_decode_tb;
  localparam logic [7:0] RP = 8'h12;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [7:0] instr_op = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00;
  logic [7:0] instr_b3 = 8'h00, reg_ptr = RP;
  logic [15:0] next_pc = 16'h1000;
  logic [5:0] flags_in = 6'h27;
  wire logic [7:0] rf_rdata, mem_rdata, rf_wdata, mem_wdata, bit_mask;
  wire logic instr_ready, done, foreign, rf_rd, rf_we, mem_space, mem_rd;
  wire logic mem_we, flags_we;
  wire logic [2:0] fetch_len;
  wire logic [11:0] rf_addr;
  wire logic [15:0] mem_addr, rel_target, direct_addr;
  wire logic [5:0] flags_out;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] ncyc;
  logic fgn;
  logic [5:0] fl;
  cpu_load_or_multiply_decode cpu_load_or_multiply_decode_inst (.*);
  mem_model mem_model_inst (.*);
  // clock
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // register file access by 12-bit address
  function automatic logic [7:0] rg(input logic [11:0] a);
    rg = mem_model_inst.rf[a];
  endfunction
  task automatic sr(input logic [11:0] a, input logic [7:0] v);
    mem_model_inst.rf[a] = v;
  endtask
  // offer one instruction, wait for done, note cycles and flags
  task automatic issue(input logic [7:0] op, b1, b2, b3);
    int k;
    k = 0;
    while (instr_ready !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    {instr_op, instr_b1, instr_b2, instr_b3} = {op, b1, b2, b3};
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    fgn = foreign;
    ncyc = 8'h00;
    for (k = 1; k <= 12; k++) begin
      if (done === 1'b1 && ncyc == 8'h00) begin
        ncyc = k[7:0];
        fl = flags_out;
      end
      if (ncyc == 8'h00)
        @(negedge sys_clk);
    end
    @(negedge sys_clk);
  endtask
  task automatic t_imm;
    for (int n = 0; n < 16; n++) begin
      issue({n[3:0], 4'hC}, 8'h30 + n[7:0], 8'h00, 8'h00);
      `CHK(rg({RP, n[3:0]}), 8'h30 + n[7:0]);
      `CHK(ncyc, 2);
      `CHK(fetch_len, 2);
    end
    $display("test imm finished");
  endtask
  task automatic t_mload;
    sr({RP, 4'h4}, 8'hAB);
    sr({RP, 4'h5}, 8'hCD);
    mem_model_inst.pm[16'hABCD] = 8'h11;
    mem_model_inst.xm[16'hABCD] = 8'h22;
    issue(8'hC2, 8'h75, 8'h00, 8'h00); // odd pair field
    `CHK(rg({RP, 4'h7}), 8'h11);
    `CHK(ncyc, 5);
    issue(8'h82, 8'h74, 8'h00, 8'h00);
    `CHK(rg({RP, 4'h7}), 8'h22);
    `CHK(ncyc, 5);
    $display("test mload finished");
  endtask
  task automatic t_autoinc;
    sr({RP, 4'h2}, 8'h40);
    sr({RP, 4'h6}, 8'h20);
    sr({RP, 4'h7}, 8'hFF);
    sr(12'h042, 8'h77);
    sr(12'h043, 8'h88);
    mem_model_inst.pm[16'h20FF] = 8'h5C;
    mem_model_inst.xm[16'h2100] = 8'h6D;
    issue(8'hC3, 8'h26, 8'h00, 8'h00);
    `CHK(rg(12'h040), 8'h5C);
    `CHK(ncyc, 9);
    `CHK({rg({RP, 4'h6}), rg({RP, 4'h7})}, 16'h2100);
    issue(8'h83, 8'h26, 8'h00, 8'h00);
    `CHK(rg(12'h041), 8'h6D);
    `CHK(ncyc, 9);
    issue(8'hD3, 8'h62, 8'h00, 8'h00);
    `CHK(mem_model_inst.pm[16'h2101], 8'h77);
    `CHK(ncyc, 9);
    issue(8'h93, 8'h62, 8'h00, 8'h00);
    `CHK(mem_model_inst.xm[16'h2102], 8'h88);
    `CHK(rg({RP, 4'h2}), 8'h44);
    `CHK({rg({RP, 4'h6}), rg({RP, 4'h7})}, 16'h2103);
    $display("test autoinc finished");
  endtask
  task automatic t_xld_lea_mul;
    sr(12'hFFF, 8'h9E);
    sr({RP, 4'h1}, 8'h10);
    sr(12'h020, 8'hFF);
    sr(12'h021, 8'hFF);
    issue(8'h84, 8'h3F, 8'hFF, 8'h00);
    `CHK(rg({RP, 4'h3}), 8'h9E);
    `CHK({ncyc, 5'h00, fetch_len}, 16'h0203);
    issue(8'h98, 8'h91, 8'hF0, 8'h00);
    `CHK(rg({RP, 4'h9}), 8'h00);
    `CHK({ncyc, 5'h00, fetch_len}, 16'h0303);
    issue(8'hF4, 8'h21, 8'h00, 8'h00);
    `CHK({rg(12'h020), rg(12'h021)}, 16'hFE01);
    `CHK({ncyc, 5'h00, fetch_len}, 16'h0802);
    $display("test xld lea mul finished");
  endtask
  task automatic t_idle_foreign;
    issue(8'h0F, 8'h00, 8'h00, 8'h00);
    `CHK({ncyc, 5'h00, fetch_len}, 16'h0201);
    `CHK(rg({RP, 4'h3}), 8'h9E);
    issue(8'h00, 8'h3F, 8'h00, 8'h00);
    `CHK({fgn, ncyc}, 9'h100);
    issue(8'h99, 8'h91, 8'h00, 8'h00);
    `CHK({fgn, ncyc}, 9'h100);
    `CHK(rg({RP, 4'h9}), 8'h00);
    $display("test idle foreign finished");
  endtask
  task automatic t_or;
    sr({RP, 4'h5}, 8'h00);
    sr({RP, 4'h6}, 8'h00);
    issue(8'h42, 8'h56, 8'h00, 8'h00);
    `CHK({ncyc, 2'h0, fl}, 16'h0333);
    sr({RP, 4'h6}, 8'h81);
    issue(8'h42, 8'h56, 8'h00, 8'h00);
    `CHK({rg({RP, 4'h5}), 2'h0, fl}, 16'h812B);
    sr(12'h3A5, 8'h0F);
    sr(12'h7B4, 8'h30);
    issue(8'h48, 8'h3A, 8'h57, 8'hB4);
    `CHK({rg(12'h7B4), 2'h0, fl}, 16'h3F23);
    `CHK({ncyc, 5'h00, fetch_len}, 16'h0304);
    $display("test or finished");
  endtask
  task automatic t_opnd;
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      v = b[0] ? 8'h80 + b[7:0] : 8'h78 + b[7:0];
      issue(8'h0F, v, 8'hC0 + b[7:0], 8'h00);
      `CHK(bit_mask, 8'h01 << b[2:0]);
      `CHK(rel_target, 16'h1000 + {{8{v[7]}}, v});
      `CHK(direct_addr, {v, 8'hC0 + b[7:0]});
    end
    $display("test operands finished");
  endtask
  // watchdog
  initial begin
    #50000;
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    t_imm;
    t_mload;
    t_autoinc;
    t_xld_lea_mul;
    t_idle_foreign;
    t_or;
    t_opnd;
    tally_and_finish;
  end
endmodule // cpu_load_or_multiply_decode_tb
bind cpu_load_or_multiply_decode decode_props decode_props_inst (.*);
`default_nettype wire
